// >>> cie_pkg.sv
// shared constants and types for the instruction execute block
package cie_pkg;

    // ********
    // widths, pointer count, reset values and direct page
    // ********
    localparam int          DATA_W      = 8;
    localparam int          ADDR_W      = 16;
    localparam int          PTR_NUM     = 4;
    localparam logic [7:0]  ACC_RST     = 8'h00;
    localparam logic [15:0] PTR_RST     = 16'h0000;
    localparam logic [7:0]  DIRECT_PAGE = 8'h00;

    // ********
    // field positions
    // ********
    localparam int SFLAG_C_BIT     = 7;
    localparam int SFLAG_CV_BIT    = 6;
    localparam int SFLAG_FULL_BIT  = 5;
    localparam int SFLAG_EMPTY_BIT = 4;
    localparam int MSB_BIT         = 7;

    // ********
    // clock divider and shift-right base
    // ********
    localparam logic [2:0] DIV_MAX_SEL = 3'h4;
    localparam logic [2:0] DIV_RST_SEL = 3'h0;
    localparam logic [3:0] SHR_BASE    = 4'h8;

    typedef enum logic [4:0] {
        CIE_OP_NOP   = 5'h00,
        CIE_OP_SUBSC = 5'h01,
        CIE_OP_MUL   = 5'h02,
        CIE_OP_MULA  = 5'h03,
        CIE_OP_MSHL  = 5'h04,
        CIE_OP_MSHR  = 5'h05,
        CIE_OP_CMP   = 5'h06,
        CIE_OP_CMPA  = 5'h07,
        CIE_OP_TSTB  = 5'h08,
        CIE_OP_SETB  = 5'h09,
        CIE_OP_CLRB  = 5'h0a,
        CIE_OP_INVB  = 5'h0b,
        CIE_OP_SFLAG = 5'h0c,
        CIE_OP_RFLAG = 5'h0d,
        CIE_OP_FREQ  = 5'h0e,
        CIE_OP_JUMP  = 5'h0f
    } cie_op_t;

    typedef enum logic [1:0] {
        CIE_SRC_REG = 2'h0,
        CIE_SRC_IMM = 2'h1,
        CIE_SRC_MEM = 2'h2
    } cie_src_t;

    typedef enum logic [2:0] {
        CIE_EA_DIRECT  = 3'h0,
        CIE_EA_IDX     = 3'h1,
        CIE_EA_IDX_OFF = 3'h2,
        CIE_EA_IDX_RG  = 3'h3,
        CIE_EA_POSTINC = 3'h4,
        CIE_EA_POSTOFF = 3'h5,
        CIE_EA_PREDEC  = 3'h6,
        CIE_EA_PREOFF  = 3'h7
    } cie_ea_t;

    typedef enum logic [3:0] {
        CIE_CC_CS = 4'h0,
        CIE_CC_CC = 4'h1,
        CIE_CC_ZS = 4'h2,
        CIE_CC_ZC = 4'h3,
        CIE_CC_VS = 4'h4,
        CIE_CC_VC = 4'h5,
        CIE_CC_EV = 4'h6,
        CIE_CC_EQ = 4'h7,
        CIE_CC_NE = 4'h8,
        CIE_CC_GT = 4'h9,
        CIE_CC_GE = 4'ha,
        CIE_CC_LT = 4'hb,
        CIE_CC_LE = 4'hc
    } cie_cc_t;

    typedef enum logic [2:0] {
        CIE_ST_IDLE = 3'b001,
        CIE_ST_MEM  = 3'b010,
        CIE_ST_EXEC = 3'b100
    } cie_state_t;

endpackage

// >>> cie_addr_gen.sv
// extended address computation and index update for one memory operand
module cie_addr_gen (
    input  wire logic [2:0]  ea_mode,
    input  wire logic [15:0] ptr_value,
    input  wire logic [7:0]  ea_byte,
    input  wire logic [7:0]  offset_register_three,
    output logic      [15:0] dm_address,
    output logic      [15:0] ptr_new,
    output logic             ptr_we
);

    logic [15:0] off16;
    logic [15:0] roff;

    always_comb begin
        off16      = {8'h00, ea_byte};
        roff       = {8'h00, offset_register_three};
        dm_address = ptr_value;
        ptr_new    = ptr_value;
        ptr_we     = 1'b0;
        case (cie_pkg::cie_ea_t'(ea_mode))
            cie_pkg::CIE_EA_DIRECT: begin
                dm_address = {cie_pkg::DIRECT_PAGE, ea_byte};
            end
            cie_pkg::CIE_EA_IDX: begin
                dm_address = ptr_value;
            end
            cie_pkg::CIE_EA_IDX_OFF: begin
                dm_address = ptr_value + off16;
            end
            cie_pkg::CIE_EA_IDX_RG: begin
                dm_address = ptr_value + roff;
            end
            cie_pkg::CIE_EA_POSTINC: begin
                dm_address = ptr_value;
                ptr_new    = ptr_value + 16'h0001;
                ptr_we     = 1'b1;
            end
            cie_pkg::CIE_EA_POSTOFF: begin
                dm_address = ptr_value + off16;
                ptr_new    = ptr_value + off16;
                ptr_we     = 1'b1;
            end
            cie_pkg::CIE_EA_PREDEC: begin
                dm_address = ptr_value - 16'h0001;
                ptr_new    = ptr_value - 16'h0001;
                ptr_we     = 1'b1;
            end
            cie_pkg::CIE_EA_PREOFF: begin
                dm_address = ptr_value - off16;
                ptr_new    = ptr_value - off16;
                ptr_we     = 1'b1;
            end
            default: ;
        endcase
    end

endmodule // cie_addr_gen

// >>> cie_execute.sv
// execute stage: arithmetic, bit, flag, clock divide, addressing and jump test
//
// Notes on behaviour
// - subtract with borrow
// - byte-split product
// - shift by multiply
// - kept and undefined flags
// - compare writes accumulator only
// - compare operand order
// - bit probe
// - bit set
// - bit clear
// - bit invert
// - status snapshot
// - shift into carry
// - clock divide, flags kept
// - access and index update together
// - eight modes, direct page zero
// - indexed offset modes keep pointer, post and pre offset modes update it
// - post increment
// - pre decrement
// - thirteen jump conditions
module cie_execute (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        op_valid,
    input  wire logic [4:0]  op_code,
    input  wire logic [1:0]  op_src,
    input  wire logic [7:0]  op_first,
    input  wire logic [7:0]  op_second,
    input  wire logic [7:0]  op_imm,
    input  wire logic [2:0]  op_bit,
    input  wire logic [3:0]  op_cond,
    input  wire logic [2:0]  ea_mode,
    input  wire logic [1:0]  ea_ptr_sel,
    input  wire logic [7:0]  ea_byte,
    input  wire logic [7:0]  offset_register_three,
    input  wire logic [7:0]  dm_rdata,
    input  wire logic        stack_full,
    input  wire logic        stack_empty,
    input  wire logic        event_line_zero,
    input  wire logic        event_line_one,
    output logic             op_ready,
    output logic             op_done,
    output logic             reg_we,
    output logic      [7:0]  reg_wdata,
    output logic      [7:0]  acc,
    output logic             flag_c,
    output logic             flag_v,
    output logic             flag_z,
    output logic             jump_taken,
    output logic             dm_re,
    output logic      [15:0] dm_addr,
    output logic             cpu_clk_en
);

    // ********
    // reset release and event pin sync
    // ********
    logic       rst_meta_reg;
    logic       rst_sync_reg;
    logic [1:0] ev_meta_reg;
    logic [1:0] ev_sync_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            ev_meta_reg <= 2'h0;
            ev_sync_reg <= 2'h0;
        end else begin
            ev_meta_reg <= {event_line_one, event_line_zero};
            ev_sync_reg <= ev_meta_reg;
        end
    end

    // ********
    // cpu clock divider
    // ********
    logic [2:0] div_sel_reg;
    logic [2:0] div_sel_next;
    logic [3:0] div_cnt_reg;
    logic [3:0] div_cnt_next;
    logic       clk_en_reg;
    logic       clk_en_next;
    logic [3:0] div_mask;
    logic       freq_wr;
    logic [2:0] freq_val;

    always_comb begin
        div_sel_next = div_sel_reg;
        div_cnt_next = div_cnt_reg + 4'h1;
        if (freq_wr) begin
            div_sel_next = freq_val;
            div_cnt_next = 4'h0;
        end
        div_mask    = 4'((5'h01 << div_sel_next) - 5'h01);
        clk_en_next = ((div_cnt_next & div_mask) == 4'h0);
    end

    always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            div_sel_reg <= cie_pkg::DIV_RST_SEL;
            div_cnt_reg <= 4'h0;
            clk_en_reg  <= 1'b0;
        end else begin
            div_sel_reg <= div_sel_next;
            div_cnt_reg <= div_cnt_next;
            clk_en_reg  <= clk_en_next;
        end
    end

    // ********
    // pointer registers
    // ********
    logic [15:0] ptr_reg [cie_pkg::PTR_NUM];
    logic [15:0] ptr_sel;
    logic [15:0] ea_addr;
    logic [15:0] ea_ptr_new;
    logic        ea_ptr_we;
    logic        accept;

    assign ptr_sel = ptr_reg[ea_ptr_sel];

    cie_addr_gen u_addr_gen (
        .ea_mode               (ea_mode),
        .ptr_value             (ptr_sel),
        .ea_byte               (ea_byte),
        .offset_register_three (offset_register_three),
        .dm_address            (ea_addr),
        .ptr_new               (ea_ptr_new),
        .ptr_we                (ea_ptr_we)
    );

    generate
        for (genvar i = 0; i < cie_pkg::PTR_NUM; i++) begin : g_ptr
            logic [15:0] ptr_next;
            always_comb begin
                ptr_next = ptr_reg[i];
                if (accept && cie_pkg::cie_src_t'(op_src) == cie_pkg::CIE_SRC_MEM
                    && ea_ptr_we && ea_ptr_sel == 2'(i)) begin
                    ptr_next = ea_ptr_new;
                end
            end
            always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
                if (!rst_sync_reg) begin
                    ptr_reg[i] <= cie_pkg::PTR_RST;
                end else begin
                    ptr_reg[i] <= ptr_next;
                end
            end
        end
    endgenerate

    // ********
    // sequencing and execution
    // ********
    cie_pkg::cie_state_t state_reg, state_next;
    cie_pkg::cie_op_t    opc_reg, opc_next;
    logic [7:0]  x_reg, x_next;
    logic [7:0]  y_reg, y_next;
    logic [2:0]  bit_reg, bit_next;
    logic [3:0]  cc_reg, cc_next;
    logic        mem_reg, mem_next;
    logic [7:0]  acc_reg, acc_next;
    logic        c_reg, c_next;
    logic        v_reg, v_next;
    logic        z_reg, z_next;
    logic        we_reg, we_next;
    logic [7:0]  wd_reg, wd_next;
    logic        done_reg, done_next;
    logic        jmp_reg, jmp_next;
    logic        re_reg, re_next;
    logic [15:0] addr_reg, addr_next;
    logic        rdy_reg, rdy_next;
    logic [7:0]  y_eff;
    logic [8:0]  diff;
    logic [15:0] prod;
    logic [3:0]  shamt;
    logic [7:0]  bmask;
    logic [7:0]  res;
    logic        zero_upd;
    logic        cond;

    assign accept = op_valid && rdy_reg;

    always_comb begin
        state_next = state_reg;
        opc_next   = opc_reg;
        x_next     = x_reg;
        y_next     = y_reg;
        bit_next   = bit_reg;
        cc_next    = cc_reg;
        mem_next   = mem_reg;
        acc_next   = acc_reg;
        c_next     = c_reg;
        v_next     = v_reg;
        z_next     = z_reg;
        we_next    = 1'b0;
        wd_next    = wd_reg;
        done_next  = 1'b0;
        jmp_next   = 1'b0;
        re_next    = 1'b0;
        addr_next  = addr_reg;
        freq_wr    = 1'b0;
        freq_val   = div_sel_reg;
        zero_upd   = 1'b0;
        res        = acc_reg;
        cond       = 1'b0;
        y_eff      = mem_reg ? dm_rdata : y_reg;
        diff       = 9'h000;
        prod       = 16'h0000;
        shamt      = 4'h0;
        bmask      = 8'(8'h01 << bit_reg);
        case (state_reg)
            cie_pkg::CIE_ST_IDLE: begin
                if (accept) begin
                    opc_next = cie_pkg::cie_op_t'(op_code);
                    x_next   = op_first;
                    bit_next = op_bit;
                    cc_next  = op_cond;
                    mem_next = (cie_pkg::cie_src_t'(op_src) == cie_pkg::CIE_SRC_MEM);
                    y_next   = (cie_pkg::cie_src_t'(op_src) == cie_pkg::CIE_SRC_IMM)
                               ? op_imm : op_second;
                    if (cie_pkg::cie_src_t'(op_src) == cie_pkg::CIE_SRC_MEM) begin
                        re_next    = 1'b1;
                        addr_next  = ea_addr;
                        state_next = cie_pkg::CIE_ST_MEM;
                    end else begin
                        state_next = cie_pkg::CIE_ST_EXEC;
                    end
                end
            end
            cie_pkg::CIE_ST_MEM: begin
                state_next = cie_pkg::CIE_ST_EXEC;
            end
            cie_pkg::CIE_ST_EXEC: begin
                state_next = cie_pkg::CIE_ST_IDLE;
                done_next  = 1'b1;
                case (opc_reg)
                    cie_pkg::CIE_OP_SUBSC: begin
                        diff     = {1'b0, x_reg} - {1'b0, y_eff} - {8'h00, ~c_reg};
                        res      = diff[7:0];
                        c_next   = ~diff[8];
                        v_next   = ~diff[8];
                        zero_upd = 1'b1;
                        we_next  = 1'b1;
                        wd_next  = res;
                    end
                    cie_pkg::CIE_OP_MUL, cie_pkg::CIE_OP_MULA: begin
                        prod    = {8'h00, x_reg} * {8'h00, y_eff};
                        res     = prod[7:0];
                        we_next = 1'b1;
                        wd_next = prod[15:8];
                    end
                    cie_pkg::CIE_OP_MSHL, cie_pkg::CIE_OP_MSHR: begin
                        shamt   = (opc_reg == cie_pkg::CIE_OP_MSHL) ? {1'b0, bit_reg}
                                  : cie_pkg::SHR_BASE - {1'b0, bit_reg};
                        prod    = {8'h00, x_reg} << shamt;
                        res     = prod[7:0];
                        we_next = 1'b1;
                        wd_next = prod[15:8];
                    end
                    cie_pkg::CIE_OP_CMP, cie_pkg::CIE_OP_CMPA: begin
                        diff     = {1'b0, y_eff} - {1'b0, x_reg};
                        res      = diff[7:0];
                        c_next   = ~diff[8];
                        v_next   = ~diff[8] && (diff[7:0] != 8'h00);
                        zero_upd = 1'b1;
                    end
                    cie_pkg::CIE_OP_TSTB: begin
                        res      = x_reg & bmask;
                        zero_upd = 1'b1;
                    end
                    cie_pkg::CIE_OP_SETB, cie_pkg::CIE_OP_CLRB, cie_pkg::CIE_OP_INVB: begin
                        if (opc_reg == cie_pkg::CIE_OP_SETB) begin
                            res = x_reg | bmask;
                        end else if (opc_reg == cie_pkg::CIE_OP_CLRB) begin
                            res = x_reg & ~bmask;
                        end else begin
                            res = x_reg ^ bmask;
                        end
                        zero_upd = 1'b1;
                        we_next  = 1'b1;
                        wd_next  = res;
                    end
                    cie_pkg::CIE_OP_SFLAG: begin
                        res = 8'h00;
                        res[cie_pkg::SFLAG_C_BIT]     = c_reg;
                        res[cie_pkg::SFLAG_CV_BIT]    = c_reg ^ v_reg;
                        res[cie_pkg::SFLAG_FULL_BIT]  = stack_full;
                        res[cie_pkg::SFLAG_EMPTY_BIT] = stack_empty;
                    end
                    cie_pkg::CIE_OP_RFLAG: begin
                        res      = {y_eff[6:0], 1'b0};
                        c_next   = y_eff[cie_pkg::MSB_BIT];
                        zero_upd = 1'b1;
                    end
                    cie_pkg::CIE_OP_FREQ: begin
                        if (y_reg[2:0] <= cie_pkg::DIV_MAX_SEL) begin
                            freq_wr  = 1'b1;
                            freq_val = y_reg[2:0];
                        end
                    end
                    cie_pkg::CIE_OP_JUMP: begin
                        case (cie_pkg::cie_cc_t'(cc_reg))
                            cie_pkg::CIE_CC_CS: cond = c_reg;
                            cie_pkg::CIE_CC_CC: cond = ~c_reg;
                            cie_pkg::CIE_CC_ZS: cond = z_reg;
                            cie_pkg::CIE_CC_ZC: cond = ~z_reg;
                            cie_pkg::CIE_CC_VS: cond = v_reg;
                            cie_pkg::CIE_CC_VC: cond = ~v_reg;
                            cie_pkg::CIE_CC_EV: cond = |ev_sync_reg;
                            cie_pkg::CIE_CC_EQ: cond = z_reg;
                            cie_pkg::CIE_CC_NE: cond = ~z_reg;
                            cie_pkg::CIE_CC_GT: cond = v_reg;
                            cie_pkg::CIE_CC_GE: cond = c_reg;
                            cie_pkg::CIE_CC_LT: cond = ~c_reg;
                            cie_pkg::CIE_CC_LE: cond = ~v_reg;
                            default:            cond = 1'b0;
                        endcase
                        jmp_next = cond;
                    end
                    default: ;
                endcase
                if (opc_reg != cie_pkg::CIE_OP_FREQ && opc_reg != cie_pkg::CIE_OP_JUMP
                    && opc_reg != cie_pkg::CIE_OP_NOP) begin
                    acc_next = res;
                end
                if (zero_upd) begin
                    z_next = (res == 8'h00);
                end
            end
            default: begin
                state_next = cie_pkg::CIE_ST_IDLE;
            end
        endcase
        rdy_next = (state_next == cie_pkg::CIE_ST_IDLE) && clk_en_next && !accept;
    end

    always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            state_reg <= cie_pkg::CIE_ST_IDLE;
            opc_reg   <= cie_pkg::CIE_OP_NOP;
            x_reg     <= 8'h00;
            y_reg     <= 8'h00;
            bit_reg   <= 3'h0;
            cc_reg    <= 4'h0;
            mem_reg   <= 1'b0;
            acc_reg   <= cie_pkg::ACC_RST;
            c_reg     <= 1'b0;
            v_reg     <= 1'b0;
            z_reg     <= 1'b0;
            we_reg    <= 1'b0;
            wd_reg    <= 8'h00;
            done_reg  <= 1'b0;
            jmp_reg   <= 1'b0;
            re_reg    <= 1'b0;
            addr_reg  <= 16'h0000;
            rdy_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            opc_reg   <= opc_next;
            x_reg     <= x_next;
            y_reg     <= y_next;
            bit_reg   <= bit_next;
            cc_reg    <= cc_next;
            mem_reg   <= mem_next;
            acc_reg   <= acc_next;
            c_reg     <= c_next;
            v_reg     <= v_next;
            z_reg     <= z_next;
            we_reg    <= we_next;
            wd_reg    <= wd_next;
            done_reg  <= done_next;
            jmp_reg   <= jmp_next;
            re_reg    <= re_next;
            addr_reg  <= addr_next;
            rdy_reg   <= rdy_next;
        end
    end

    assign op_ready   = rdy_reg;
    assign op_done    = done_reg;
    assign reg_we     = we_reg;
    assign reg_wdata  = wd_reg;
    assign acc        = acc_reg;
    assign flag_c     = c_reg;
    assign flag_v     = v_reg;
    assign flag_z     = z_reg;
    assign jump_taken = jmp_reg;
    assign dm_re      = re_reg;
    assign dm_addr    = addr_reg;
    assign cpu_clk_en = clk_en_reg;

endmodule // cie_execute

// >>> cie_execute_asserts.sv
// port-level assertions for the instruction execute block
module cie_execute_chk (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        op_valid,
    input wire logic        op_ready,
    input wire logic [4:0]  op_code,
    input wire logic [1:0]  op_src,
    input wire logic [2:0]  op_bit,
    input wire logic [2:0]  ea_mode,
    input wire logic [7:0]  ea_byte,
    input wire logic        op_done,
    input wire logic        reg_we,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  acc,
    input wire logic        flag_c,
    input wire logic        flag_v,
    input wire logic        flag_z,
    input wire logic        jump_taken,
    input wire logic        dm_re,
    input wire logic [15:0] dm_addr
);
    // ********
    // helpers
    // ********
    logic [4:0] op_reg;
    logic [2:0] bit_reg;
    wire        take = op_valid && op_ready;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            op_reg  <= 5'h00;
            bit_reg <= 3'h0;
        end else if (take) begin
            op_reg  <= op_code;
            bit_reg <= op_bit;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ********
    // assertions
    // ********
    a_take_busy: assert property (take |=> !op_ready)
        else $error("ready after take");
    a_reg_answer: assert property (take && op_src != cie_pkg::CIE_SRC_MEM
        && op_code != cie_pkg::CIE_OP_NOP |-> ##2 op_done) else $error("late done");
    a_mem_answer: assert property (take && op_src == cie_pkg::CIE_SRC_MEM
        && op_code == cie_pkg::CIE_OP_CMP |=> dm_re ##2 op_done) else $error("memory timing");
    a_direct_page: assert property (take && op_src == cie_pkg::CIE_SRC_MEM
        && op_code == cie_pkg::CIE_OP_CMP && ea_mode == cie_pkg::CIE_EA_DIRECT
        |=> dm_addr == {8'h00, $past(ea_byte)}) else $error("direct address wrong");
    a_cmp_flags: assert property (op_done && op_reg inside {[6:7]} |-> !reg_we
        && flag_v == (flag_c && !flag_z)) else $error("compare result");
    a_zero_flag: assert property (op_done && op_reg inside {[6:11]}
        |-> flag_z == (acc == 8'h00)) else $error("zero flag wrong");
    a_probe_mask: assert property (op_done && op_reg == cie_pkg::CIE_OP_TSTB
        |-> (acc & ~(8'h01 << bit_reg)) == 8'h00) else $error("probe bits");
    a_bit_copy: assert property (op_done && op_reg inside {[9:11]}
        |-> reg_we && acc == reg_wdata) else $error("bit op copy wrong");
    a_jump_pulse: assert property (jump_taken
        |-> op_done && op_reg == cie_pkg::CIE_OP_JUMP) else $error("stray jump");
    a_flags_kept: assert property (op_done && op_reg inside {[14:15]}
        |-> $stable({flag_c, flag_v, flag_z, acc})) else $error("flags changed");
    c_jump: cover property (jump_taken);
    c_mem: cover property (dm_re);
    c_write: cover property (op_done && reg_we);
endmodule // cie_execute_chk

bind cie_execute cie_execute_chk u_chk (.*);

// >>> cie_execute_tb.sv
// self-checking bench for the instruction execute block
module cie_execute_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys, rst_n = 1'b0, op_valid = 1'b0, op_ready, op_done, reg_we;
    logic        flag_c, flag_v, flag_z, jump_taken, dm_re, cpu_clk_en, c, v, z;
    logic        stack_full = 1'b0, stack_empty = 1'b1;
    logic        event_line_zero = 1'b0, event_line_one = 1'b0;
    logic [4:0]  op_code = 5'h00;
    logic [1:0]  op_src = 2'h0, ea_ptr_sel = 2'h0, psel = 2'h0;
    logic [2:0]  op_bit = 3'h0, ea_mode = 3'h0, mdv = 3'h0;
    logic [3:0]  op_cond = 4'h0, cnd = 4'h0;
    logic [7:0]  op_first = 8'h00, op_second = 8'h00, op_imm = 8'h00, ea_byte = 8'h00;
    logic [7:0]  offset_register_three = 8'h10, dm_rdata = 8'hff, reg_wdata, acc, eb = 8'h00;
    logic [15:0] dm_addr;
    int          miscompares = 0, check_count = 0;

    cie_execute dut (.*);

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // memory answers the cycle after a read
    always @(posedge clk_sys) begin
        dm_rdata <= dm_re ? op_second : ~op_second;
    end

    task automatic end_sim;
        if (miscompares == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic run(input logic [4:0] o, input logic [1:0] sr, input logic [7:0] f, s,
                       input logic [2:0] b);
        int n = 0;
        @(posedge clk_sys);
        op_valid   <= 1'b1;
        op_code    <= o;
        op_src     <= sr;
        op_first   <= f;
        op_second  <= s;
        op_imm     <= s;
        op_bit     <= b;
        op_cond    <= cnd;
        ea_mode    <= mdv;
        ea_ptr_sel <= psel;
        ea_byte    <= eb;
        do @(negedge clk_sys); while (op_ready !== 1'b1 && ++n < 40);
        @(posedge clk_sys);
        op_valid <= 1'b0;
        do @(negedge clk_sys); while (op_done !== 1'b1 && ++n < 80);
        if (n >= 80) chk(24'h0, 24'h1, "no done");
    endtask

    task automatic cmp_jump(input logic [4:0] o, input logic [1:0] sr, input logic [7:0] f, s,
                            input logic [1:0] ev);
        logic [12:0] tk;
        @(posedge clk_sys);
        event_line_zero <= ev[0];
        event_line_one  <= ev[1];
        run(o, sr, f, s, 3'h0);
        c = s >= f;
        z = s == f;
        v = c && !z;
        chk({reg_we, flag_c, flag_v, flag_z, acc}, {1'b0, c, v, z, s - f}, "cmp");
        tk = {!v, !c, c, v, !z, z, |ev, !v, v, !z, z, !c, c};
        for (int k = 0; k < 13; k++) begin
            cnd = k[3:0];
            run(cie_pkg::CIE_OP_JUMP, cie_pkg::CIE_SRC_REG, f, s, 3'h0);
            chk(jump_taken, tk[k], "jump");
        end
    endtask

    task automatic t_arith;
        run(cie_pkg::CIE_OP_SUBSC, cie_pkg::CIE_SRC_IMM, 8'h10, 8'h05, 3'h0);
        chk({flag_c, flag_z, reg_wdata, acc}, {2'b10, 16'h0a0a}, "subsc imm");
        run(cie_pkg::CIE_OP_SUBSC, cie_pkg::CIE_SRC_REG, 8'h03, 8'h03, 3'h0);
        chk({flag_c, flag_z, reg_wdata, acc}, {2'b11, 16'h0000}, "subsc reg");
        run(cie_pkg::CIE_OP_SUBSC, cie_pkg::CIE_SRC_MEM, 8'h00, 8'h01, 3'h0);
        chk({flag_c, flag_z, reg_wdata, acc}, {2'b00, 16'hffff}, "subsc mem");
        run(cie_pkg::CIE_OP_MUL, cie_pkg::CIE_SRC_IMM, 8'hc8, 8'h96, 3'h0);
        chk({reg_wdata, acc}, 24'h7530, "mul imm");
        run(cie_pkg::CIE_OP_MULA, cie_pkg::CIE_SRC_MEM, 8'hff, 8'hff, 3'h0);
        chk({reg_wdata, acc}, 24'hfe01, "mula mem");
        for (int n = 0; n < 8; n++) begin
            run(cie_pkg::CIE_OP_MSHL, cie_pkg::CIE_SRC_IMM, 8'hb5, 8'h00, n[2:0]);
            chk({reg_wdata, acc}, 24'h00b5 << n, "shift left");
            run(cie_pkg::CIE_OP_MSHR, cie_pkg::CIE_SRC_IMM, 8'hb5, 8'h00, n[2:0]);
            chk({reg_wdata, acc}, 24'h00b5 << (8 - n), "shift right");
        end
    endtask

    task automatic t_bits;
        logic [7:0] m, r;
        for (int k = 8; k < 12; k++) begin
            for (int n = 0; n < 8; n++) begin
                m = 8'h01 << n;
                r = k == 9 ? 8'ha5 | m : k == 10 ? 8'ha5 & ~m : k == 11 ? 8'ha5 ^ m : 8'ha5 & m;
                run(k[4:0], cie_pkg::CIE_SRC_REG, 8'ha5, 8'h00, n[2:0]);
                chk({flag_c, flag_v, flag_z, acc}, {c, v, r == 8'h00, r}, "bit");
                if (k != 8) chk(reg_wdata, r, "bit reg");
            end
        end
    endtask

    task automatic t_addr;
        logic [31:0] tb_tbl[12] = '{32'h51400040, 32'h11000040, 32'h21050045, 32'h31000050,
            32'h41000040, 32'h11000041, 32'h61000040, 32'h71200020, 32'h11000020,
            32'h6200ffff, 32'h1200ffff, 32'h019c009c};
        for (int i = 0; i < 12; i++) begin
            mdv  = tb_tbl[i][30:28];
            psel = tb_tbl[i][25:24];
            eb   = tb_tbl[i][23:16];
            run(cie_pkg::CIE_OP_CMP, cie_pkg::CIE_SRC_MEM, 8'h00, 8'h55, 3'h0);
            chk(dm_addr, tb_tbl[i][15:0], "address");
        end
    endtask

    task automatic t_misc;
        int n;
        @(posedge clk_sys);
        stack_full  <= 1'b1;
        stack_empty <= 1'b0;
        run(cie_pkg::CIE_OP_SFLAG, cie_pkg::CIE_SRC_REG, 8'h00, 8'h00, 3'h0);
        chk({flag_c, flag_v, acc[7:4]}, 6'h3a, "snapshot");
        run(cie_pkg::CIE_OP_RFLAG, cie_pkg::CIE_SRC_REG, 8'h00, 8'h81, 3'h0);
        chk({flag_c, acc}, 24'h102, "rotate reg");
        run(cie_pkg::CIE_OP_RFLAG, cie_pkg::CIE_SRC_MEM, 8'h00, 8'h40, 3'h0);
        chk({flag_c, acc}, 24'h080, "rotate mem");
        for (int s = 5; s >= 0; s--) begin
            run(cie_pkg::CIE_OP_FREQ, cie_pkg::CIE_SRC_IMM, 8'h00, s[7:0], 3'h0);
            chk({flag_c, acc}, 24'h080, "divide kept flags");
            n = 0;
            repeat (32) @(negedge clk_sys) n += cpu_clk_en;
            chk(n, s > 4 ? 32 : 32 >> s, "divide rate");
        end
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        end_sim;
    end

    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_arith;
        cmp_jump(cie_pkg::CIE_OP_CMP, cie_pkg::CIE_SRC_IMM, 8'h20, 8'h30, 2'h2);
        cmp_jump(cie_pkg::CIE_OP_CMP, cie_pkg::CIE_SRC_REG, 8'h40, 8'h40, 2'h1);
        cmp_jump(cie_pkg::CIE_OP_CMPA, cie_pkg::CIE_SRC_MEM, 8'h20, 8'h10, 2'h0);
        t_bits;
        t_addr;
        t_misc;
        end_sim;
    end
endmodule // cie_execute_tb
